// ---- design/rff_buf.sv ----
`timescale 1ns/1ps
module rff_buf import rff_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  // filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("rff_buf depth must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } rff_buf_st_t;

  rff_buf_st_t s;
  rff_buf_st_t next_s;
  logic        full;
  logic        empty;

  // pointer compare: same slot, wrap bit tells full from empty
  assign empty       = s.wr == s.rd;
  assign full        = s.wr[AW-1:0] == s.rd[AW-1:0] && s.wr[AW] != s.rd[AW];
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = s.mem[s.rd[AW-1:0]];

  // push and pop
  always_comb begin
    next_s = s;
    if (in_valid_i && !full) begin
      next_s.mem[s.wr[AW-1:0]] = in_data_i;
      next_s.wr = s.wr + 1'b1;
    end
    if (out_ready_i && !empty) begin
      next_s.rd = s.rd + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule // rff_buf

// ---- design/rff_pkg.sv ----
package rff_pkg;
  // register map (10-bit register address space)
  localparam logic [9:0] RFF_MODE_REG   = 10'h000;
  localparam logic [9:0] RFF_PAN_LO     = 10'h001;
  localparam logic [9:0] RFF_PAN_HI     = 10'h002;
  localparam logic [9:0] RFF_SADR_LO    = 10'h003;
  localparam logic [9:0] RFF_SADR_HI    = 10'h004;
  localparam logic [9:0] RFF_EADR_BASE  = 10'h005;
  localparam logic [9:0] RFF_EADR_LAST  = 10'h00C;
  localparam logic [9:0] RFF_FLUSH_REG  = 10'h00D;
  localparam logic [9:0] RFF_LIFS_REG   = 10'h021;
  localparam logic [9:0] RFF_TURN_REG   = 10'h027;
  localparam logic [9:0] RFF_SOFTRST    = 10'h02A;
  localparam logic [9:0] RFF_SETTLE_REG = 10'h02E;
  localparam logic [9:0] RFF_INTERRUPT_STATUS_REG    = 10'h031;
  localparam logic [9:0] RFF_BB_REG     = 10'h039;
  localparam logic [9:0] RFF_RXBUF_BASE = 10'h300;
  localparam logic [9:0] RFF_RXBUF_LAST = 10'h38F;
  // bit and field positions
  localparam int RFF_COORD_BIT  = 3;
  localparam int RFF_FLUSH_BIT  = 0;
  localparam int RFF_FILT_LSB   = 1;
  localparam int RFF_FILT_MSB   = 3;
  localparam int RFF_RSTMAC_BIT = 0;
  localparam int RFF_RXFLAG_BIT = 3;
  localparam int RFF_DECINV_BIT = 2;
  localparam int RFF_SIFS_LSB   = 0;
  localparam int RFF_SIFS_MSB   = 3;
  localparam int RFF_SETTLE_LSB = 4;
  localparam int RFF_SETTLE_MSB = 7;
  localparam int RFF_LIFS_LSB   = 2;
  localparam int RFF_LIFS_MSB   = 7;
  localparam int RFF_TURN_LSB   = 4;
  localparam int RFF_TURN_MSB   = 7;
  // reset values (sifs 12, lifs 40, turnaround 12, settle 0)
  localparam logic [7:0] RFF_SETTLE_RST = 8'h0C;
  localparam logic [7:0] RFF_LIFS_RST   = 8'hA0;
  localparam logic [7:0] RFF_TURN_RST   = 8'hC0;
  // reception modes and frame-type filter
  localparam logic [1:0] RFF_RX_NORMAL = 2'h0;
  localparam logic [1:0] RFF_RX_ERROR  = 2'h2;
  localparam logic [1:0] RFF_RX_PROMI  = 2'h1;
  localparam logic [2:0] RFF_FILT_ALL  = 3'h0;
  localparam int RFF_FILT_CMD_BIT  = 2;
  localparam int RFF_FILT_DATA_BIT = 1;
  localparam int RFF_FILT_BCN_BIT  = 0;
  // frame control field
  localparam logic [2:0] RFF_FT_BCN  = 3'h0;
  localparam logic [2:0] RFF_FT_DATA = 3'h1;
  localparam logic [2:0] RFF_FT_CMD  = 3'h3;
  localparam int RFF_ACKREQ_BIT  = 5;
  localparam int RFF_PANCOMP_BIT = 6;
  localparam logic [1:0] RFF_AM_NONE  = 2'h0;
  localparam logic [1:0] RFF_AM_SHORT = 2'h2;
  localparam logic [1:0] RFF_AM_EXT   = 2'h3;
  localparam logic [15:0] RFF_BCAST   = 16'hFFFF;
  // byte positions inside the frame
  localparam logic [7:0] RFF_POS_FC0  = 8'h00;
  localparam logic [7:0] RFF_POS_FC1  = 8'h01;
  localparam logic [7:0] RFF_POS_SEQ  = 8'h02;
  localparam logic [7:0] RFF_POS_ADDR = 8'h03;
  localparam logic [7:0] RFF_PAN_LEN  = 8'h02;
  localparam logic [7:0] RFF_SHORT_LEN = 8'h02;
  localparam logic [7:0] RFF_EXT_LEN  = 8'h08;
  // timing
  localparam int RFF_SYM_NS = 16000;
  localparam int RFF_CLK_NS = 25;
  localparam int RFF_SYM_CYC = (RFF_SYM_NS + RFF_CLK_NS - 1) / RFF_CLK_NS;
  localparam logic [7:0] RFF_MAX_SIFS_LEN = 8'h12;
  // parser and timer states
  typedef enum logic [2:0] {
    P_IDLE = 3'h0, P_BODY = 3'h1, P_LQI = 3'h3, P_RSSI = 3'h2,
    P_DROP = 3'h6
  } rff_pstate_t;
  typedef enum logic [1:0] {
    T_IDLE = 2'h0, T_TURN = 2'h1, T_IFS = 2'h3, T_WACK = 2'h2
  } rff_tstate_t;
  // one demodulated byte with frame markers
  typedef struct packed {
    logic       first;
    logic       last;
    logic       crc_ok;
    logic [7:0] lqi;
    logic [7:0] rssi;
    logic [7:0] data;
  } rff_word_t;
endpackage

// ---- design/rff_rx_filter.sv ----
`timescale 1ns/1ps
module rff_rx_filter import rff_pkg::*; #(
  parameter int BUF_BYTES = 128,
  parameter int SYM_CYC   = RFF_SYM_CYC
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // demodulated byte stream
  input  wire logic       rx_valid_i,
  output logic            rx_ready_o,
  input  wire rff_word_t  rx_word_i,
  // register access port
  input  wire logic [9:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic [7:0]      reg_rdata_o,
  output logic            reg_rvalid_o,
  // transmit timing and receive flag
  input  wire logic       tx_done_i,
  input  wire logic [7:0] tx_len_i,
  input  wire logic       tx_ackreq_i,
  input  wire logic       ack_rcvd_i,
  output logic            ack_tx_o,
  output logic [7:0]      ack_seq_o,
  output logic            ifs_busy_o,
  output logic            rx_flag_o
);
  localparam int PW = $clog2(BUF_BYTES);
  localparam int CW = $clog2(SYM_CYC);

  if (BUF_BYTES < 4 || BUF_BYTES > 144 || SYM_CYC < 2) begin : g_bad
    $error("rff_rx_filter parameters out of range");
  end

  typedef struct packed {
    logic [BUF_BYTES-1:0][7:0] mem;
    logic [PW:0]  wp;
    rff_pstate_t  ps;
    logic [7:0]   pos;
    logic [7:0]   fc0;
    logic [7:0]   fc1;
    logic [7:0]   seq;
    logic [15:0]  dpan;
    logic [63:0]  dadr;
    logic [15:0]  span;
    logic [7:0]   lqi;
    logic [7:0]   rssi;
    logic         full;
    logic         flag;
    logic         ack_pend;
    logic [7:0]   ack_seq;
    logic         ack_tx;
    rff_tstate_t  ts;
    logic [6:0]   sym_left;
    logic [CW-1:0] pre;
    logic         tx_long;
    logic [7:0]   mode_reg;
    logic [15:0]  pan;
    logic [15:0]  sadr;
    logic [63:0]  eadr;
    logic [2:0]   filt;
    logic [7:0]   lifs_reg;
    logic [3:0]   turn;
    logic [7:0]   settle_reg;
    logic         decinv;
    logic [7:0]   rdata;
    logic         rvalid;
  } rff_st_t;

  rff_st_t   s;
  rff_st_t   next_s;
  rff_word_t w;
  logic      w_valid;
  logic      take;
  logic      drain_ready;

  // two-entry buffer in front of the parser
  rff_buf #(
    .WIDTH ($bits(rff_word_t)),
    .DEPTH (2)
  ) u_buf (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (rx_valid_i),
    .in_ready_o  (rx_ready_o),
    .in_data_i   (rx_word_i),
    .out_valid_o (w_valid),
    .out_ready_i (drain_ready),
    .out_data_o  (w)
  );

  // parser stalls while it appends the quality bytes
  assign drain_ready = s.ps != P_LQI && s.ps != P_RSSI;
  assign take        = w_valid && drain_ready;

  // addressing layout from the frame control field
  logic [2:0]  ftype;
  logic [1:0]  dmode;
  logic [1:0]  smode;
  logic [7:0]  dpl;
  logic [7:0]  dal;
  logic [7:0]  spl;
  logic [7:0]  dadr_lo;
  logic [7:0]  span_lo;
  logic [7:0]  span_hi;
  logic [15:0] span_eff;
  logic [15:0] dshort;

  assign ftype    = s.fc0[2:0];
  assign dmode    = s.fc1[3:2];
  assign smode    = s.fc1[7:6];
  assign dpl      = dmode != RFF_AM_NONE ? RFF_PAN_LEN : 8'h00;
  assign dal      = dmode == RFF_AM_SHORT ? RFF_SHORT_LEN :
                    dmode == RFF_AM_EXT ? RFF_EXT_LEN : 8'h00;
  assign spl      = smode != RFF_AM_NONE && !s.fc0[RFF_PANCOMP_BIT]
                    ? RFF_PAN_LEN : 8'h00;
  assign dadr_lo  = 8'(RFF_POS_ADDR + dpl);
  assign span_lo  = 8'(dadr_lo + dal);
  assign span_hi  = 8'(span_lo + spl);
  assign span_eff = s.fc0[RFF_PANCOMP_BIT] ? s.dpan : s.span;
  assign dshort   = s.dadr[63:48];

  // acceptance checks, evaluated at the last byte
  logic is_bcn;
  logic is_dc;
  logic legal_ok;
  logic bcn_ok;
  logic dpan_ok;
  logic dadr_ok;
  logic srco_ok;
  logic norm_ok;
  logic mode_ok;
  logic filt_ok;
  logic [1:0] rx_mode;

  assign rx_mode  = s.mode_reg[1:0];
  assign is_bcn   = ftype == RFF_FT_BCN;
  assign is_dc    = ftype == RFF_FT_DATA || ftype == RFF_FT_CMD;
  assign legal_ok = ftype <= RFF_FT_CMD;
  assign bcn_ok   = !is_bcn || s.pan == RFF_BCAST
                    || span_eff == s.pan;
  assign dpan_ok  = dmode == RFF_AM_NONE || s.dpan == s.pan
                    || s.dpan == RFF_BCAST;
  assign dadr_ok  = dmode == RFF_AM_SHORT
                    ? (dshort == s.sadr || dshort == RFF_BCAST)
                    : dmode == RFF_AM_EXT ? s.dadr == s.eadr
                    : 1'b1;
  assign srco_ok  = !(dmode == RFF_AM_NONE && smode != RFF_AM_NONE
                    && is_dc)
                    || (s.mode_reg[RFF_COORD_BIT]
                    && span_eff == s.pan);
  assign norm_ok  = w.crc_ok && legal_ok && bcn_ok && dpan_ok
                    && dadr_ok && srco_ok;

  // reception mode select
  always_comb begin
    case (rx_mode)
      RFF_RX_ERROR: mode_ok = 1'b1;
      RFF_RX_PROMI: mode_ok = w.crc_ok;
      default:      mode_ok = norm_ok;
    endcase
  end

  // frame-type filter after acceptance
  assign filt_ok = s.filt == RFF_FILT_ALL
                   || (s.filt[RFF_FILT_CMD_BIT] && ftype == RFF_FT_CMD)
                   || (s.filt[RFF_FILT_DATA_BIT] && ftype == RFF_FT_DATA)
                   || (s.filt[RFF_FILT_BCN_BIT] && is_bcn);

  // spacing counts in symbols
  logic [6:0]   sifs_sym;
  logic [6:0]   lifs_sym;
  logic [6:0]   turn_sym;
  logic [6:0]   settle;
  logic [9:0]   buf_idx;
  logic         wr_hit;
  logic         rd_hit;

  assign settle   = 7'(s.settle_reg[RFF_SETTLE_MSB:RFF_SETTLE_LSB]);
  assign sifs_sym = 7'(s.settle_reg[RFF_SIFS_MSB:RFF_SIFS_LSB])
                    + settle;
  assign lifs_sym = 7'(s.lifs_reg[RFF_LIFS_MSB:RFF_LIFS_LSB])
                    + settle;
  assign turn_sym = 7'(s.turn) + settle;
  assign buf_idx  = reg_addr_i - RFF_RXBUF_BASE;
  assign wr_hit   = reg_wr_i;
  assign rd_hit   = reg_rd_i && !reg_wr_i;

  // next-state logic for parser, registers and timer
  always_comb begin
    next_s = s;
    next_s.ack_tx = 1'b0;
    next_s.rvalid = rd_hit;
    // status read clears, a same-cycle set wins below
    if (rd_hit && reg_addr_i == RFF_INTERRUPT_STATUS_REG) begin
      next_s.flag = 1'b0;
    end
    // byte parser
    case (s.ps)
      P_IDLE: begin
        if (take && w.first && !w.last) begin
          if (s.full || s.decinv) begin
            next_s.ps = P_DROP;
          end else begin
            next_s.mem[0] = w.data;
            next_s.wp     = (PW+1)'(1);
            next_s.pos    = 8'h00;
            next_s.ps     = P_BODY;
          end
        end
      end
      P_BODY: begin
        if (take) begin
          if (!s.wp[PW]) begin
            next_s.mem[s.wp[PW-1:0]] = w.data;
            next_s.wp = s.wp + 1'b1;
            if (s.wp[PW-1:0] == PW'(BUF_BYTES - 1)) begin
              next_s.wp = {1'b1, PW'(0)};
            end
          end
          next_s.pos = s.pos + 8'h01;
          if (s.pos == RFF_POS_FC0) next_s.fc0 = w.data;
          if (s.pos == RFF_POS_FC1) next_s.fc1 = w.data;
          if (s.pos == RFF_POS_SEQ) next_s.seq = w.data;
          if (s.pos >= RFF_POS_ADDR && s.pos < dadr_lo) begin
            next_s.dpan = {w.data, s.dpan[15:8]};
          end
          if (s.pos >= dadr_lo && s.pos < span_lo) begin
            next_s.dadr = {w.data, s.dadr[63:8]};
          end
          if (s.pos >= span_lo && s.pos < span_hi) begin
            next_s.span = {w.data, s.span[15:8]};
          end
          if (w.last) begin
            if (mode_ok && filt_ok) begin
              next_s.lqi  = w.lqi;
              next_s.rssi = w.rssi;
              next_s.ps   = P_LQI;
            end else begin
              next_s.wp = '0;
              next_s.ps = P_IDLE;
            end
          end
        end
      end
      P_LQI: begin
        if (!s.wp[PW]) begin
          next_s.mem[s.wp[PW-1:0]] = s.lqi;
          next_s.wp = s.wp + 1'b1;
          if (s.wp[PW-1:0] == PW'(BUF_BYTES - 1)) begin
            next_s.wp = {1'b1, PW'(0)};
          end
        end
        next_s.ps = P_RSSI;
      end
      P_RSSI: begin
        if (!s.wp[PW]) begin
          next_s.mem[s.wp[PW-1:0]] = s.rssi;
        end
        next_s.full = 1'b1;
        next_s.flag = 1'b1;
        if (s.fc0[RFF_ACKREQ_BIT]) begin
          next_s.ack_pend = 1'b1;
          next_s.ack_seq  = s.seq;
        end
        next_s.ps = P_IDLE;
      end
      P_DROP: begin
        if (take && w.last) begin
          next_s.ps = P_IDLE;
        end
      end
      default: next_s.ps = P_IDLE;
    endcase
    // host register writes
    if (wr_hit) begin
      case (reg_addr_i)
        RFF_MODE_REG:   next_s.mode_reg = reg_wdata_i;
        RFF_PAN_LO:     next_s.pan[7:0] = reg_wdata_i;
        RFF_PAN_HI:     next_s.pan[15:8] = reg_wdata_i;
        RFF_SADR_LO:    next_s.sadr[7:0] = reg_wdata_i;
        RFF_SADR_HI:    next_s.sadr[15:8] = reg_wdata_i;
        RFF_FLUSH_REG:  next_s.filt =
          reg_wdata_i[RFF_FILT_MSB:RFF_FILT_LSB];
        RFF_LIFS_REG:   next_s.lifs_reg = reg_wdata_i;
        RFF_TURN_REG:   next_s.turn =
          reg_wdata_i[RFF_TURN_MSB:RFF_TURN_LSB];
        RFF_SETTLE_REG: next_s.settle_reg = reg_wdata_i;
        RFF_BB_REG:     next_s.decinv = reg_wdata_i[RFF_DECINV_BIT];
        default: begin
          if (reg_addr_i >= RFF_EADR_BASE
              && reg_addr_i <= RFF_EADR_LAST) begin
            next_s.eadr[8*(reg_addr_i - RFF_EADR_BASE) +: 8] =
              reg_wdata_i;
          end
        end
      endcase
    end
    // pointer resets: flush, soft reset, first-byte read
    if ((wr_hit && reg_addr_i == RFF_FLUSH_REG
         && reg_wdata_i[RFF_FLUSH_BIT])
        || (wr_hit && reg_addr_i == RFF_SOFTRST
         && reg_wdata_i[RFF_RSTMAC_BIT])
        || (rd_hit && reg_addr_i == RFF_RXBUF_BASE)) begin
      next_s.wp   = '0;
      next_s.full = s.ps == P_RSSI; // a same-cycle store wins
      next_s.ps   = P_IDLE;
    end
    // host register reads
    next_s.rdata = 8'h00;
    if (rd_hit) begin
      case (reg_addr_i)
        RFF_MODE_REG:   next_s.rdata = s.mode_reg;
        RFF_PAN_LO:     next_s.rdata = s.pan[7:0];
        RFF_PAN_HI:     next_s.rdata = s.pan[15:8];
        RFF_SADR_LO:    next_s.rdata = s.sadr[7:0];
        RFF_SADR_HI:    next_s.rdata = s.sadr[15:8];
        RFF_FLUSH_REG:  next_s.rdata = {4'h0, s.filt, 1'b0};
        RFF_LIFS_REG:   next_s.rdata = s.lifs_reg;
        RFF_TURN_REG:   next_s.rdata = {s.turn, 4'h0};
        RFF_SETTLE_REG: next_s.rdata = s.settle_reg;
        RFF_INTERRUPT_STATUS_REG:    next_s.rdata = 8'(s.flag) << RFF_RXFLAG_BIT;
        RFF_BB_REG:     next_s.rdata = 8'(s.decinv) << RFF_DECINV_BIT;
        default: begin
          if (reg_addr_i >= RFF_EADR_BASE
              && reg_addr_i <= RFF_EADR_LAST) begin
            next_s.rdata = s.eadr[8*(reg_addr_i - RFF_EADR_BASE) +: 8];
          end else if (reg_addr_i >= RFF_RXBUF_BASE
                       && reg_addr_i <= RFF_RXBUF_LAST
                       && buf_idx < 10'(BUF_BYTES)) begin
            next_s.rdata = s.mem[buf_idx[PW-1:0]];
          end
        end
      endcase
    end
    // symbol prescaler for the spacing timer
    if (s.ts == T_TURN || s.ts == T_IFS) begin
      if (s.sym_left != 7'h00) begin
        next_s.pre = s.pre + 1'b1;
        if (s.pre == CW'(SYM_CYC - 1)) begin
          next_s.pre      = '0;
          next_s.sym_left = s.sym_left - 7'h01;
        end
      end
    end
    // spacing and turnaround timer
    case (s.ts)
      T_IDLE: begin
        next_s.pre = '0;
        if (tx_done_i) begin
          next_s.tx_long = tx_len_i > RFF_MAX_SIFS_LEN;
          if (tx_ackreq_i) begin
            next_s.ts = T_WACK;
          end else begin
            next_s.ts = T_IFS;
            next_s.sym_left = tx_len_i > RFF_MAX_SIFS_LEN
                              ? lifs_sym : sifs_sym;
          end
        end else if (s.ack_pend) begin
          next_s.ack_pend = 1'b0;
          next_s.ts       = T_TURN;
          next_s.sym_left = turn_sym;
        end
      end
      T_TURN: begin
        if (s.sym_left == 7'h00) begin
          next_s.ack_tx   = 1'b1;
          next_s.tx_long  = 1'b0;
          next_s.ts       = T_IFS;
          next_s.sym_left = sifs_sym;
          next_s.pre      = '0;
        end
      end
      T_WACK: begin
        if (ack_rcvd_i) begin
          next_s.ts       = T_IFS;
          next_s.sym_left = s.tx_long ? lifs_sym : sifs_sym;
          next_s.pre      = '0;
        end
      end
      T_IFS: begin
        if (s.sym_left == 7'h00) begin
          next_s.ts = T_IDLE;
        end
      end
      default: next_s.ts = T_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s            <= '0;
      s.ps         <= P_IDLE;
      s.ts         <= T_IDLE;
      s.lifs_reg   <= RFF_LIFS_RST;
      s.turn       <= RFF_TURN_RST[RFF_TURN_MSB:RFF_TURN_LSB];
      s.settle_reg <= RFF_SETTLE_RST;
    end else begin
      s <= next_s;
    end
  end

  // outputs
  assign reg_rdata_o  = s.rdata;
  assign reg_rvalid_o = s.rvalid;
  assign ack_tx_o     = s.ack_tx;
  assign ack_seq_o    = s.ack_seq;
  assign ifs_busy_o   = s.ts != T_IDLE;
  assign rx_flag_o    = s.flag;
endmodule // rff_rx_filter

// ---- sim/rff_phy_src.sv ----
`timescale 1ns/1ps
module rff_phy_src import rff_pkg::*; (
  // clock
  input  wire logic clk_i,
  // byte stream
  input  wire logic rdy_i,
  output logic      valid_o,
  output rff_word_t word_o
);
  logic [7:0] q[$];   // bytes of the next frame, length byte first
  logic       crc_ok; // verdict handed with the last byte
  initial begin
    valid_o = 1'b0;
    word_o  = '0;
    crc_ok  = 1'b1;
  end
  // each byte is held until taken or 50 edges pass; released lines show inverted data
  task automatic send(input int gap, output bit hung);
    int k;
    hung = 0;
    @(posedge clk_i); // requests start on a clock edge
    foreach (q[i]) begin
      valid_o <= 1'b1;
      word_o <= '{first: i == 0, last: i == q.size() - 1, crc_ok: crc_ok,
                  lqi: 8'h11, rssi: 8'h22, data: q[i]};
      k = 0;
      do begin @(posedge clk_i); k++; end while (!rdy_i && k < 50);
      hung |= !rdy_i;
      if (gap > 0 || i == q.size() - 1) begin
        valid_o <= 1'b0;
        word_o.data <= ~q[i];
        repeat (gap) @(posedge clk_i);
      end
    end
  endtask
endmodule // rff_phy_src

// ---- sim/rff_rx_filter_assertions.sv ----
`timescale 1ns/1ps
module rff_rx_filter_chk import rff_pkg::*; (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       srst_i,
  // register port
  input wire logic [9:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       reg_rvalid_o,
  // timing and flags
  input wire logic       tx_done_i,
  input wire logic       ack_tx_o,
  input wire logic       ifs_busy_o,
  input wire logic       rx_flag_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // a plain read request and a status read
  sequence rd_s; reg_rd_i && !reg_wr_i; endsequence
  sequence stat_s; rd_s ##0 reg_addr_i == RFF_INTERRUPT_STATUS_REG ##0 rx_flag_o;
  endsequence
  read_answer_a: assert property (rd_s |=> reg_rvalid_o)
    else $error("read not answered");
  no_answer_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("answer without read");
  rdata_idle_a: assert property (!reg_rvalid_o |-> reg_rdata_o == 8'h00)
    else $error("read data not zero while idle");
  unmapped_zero_a: assert property
    (rd_s ##0 reg_addr_i == 10'h3FF |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  stat_read_a: assert property (stat_s |=> reg_rdata_o == 8'h08)
    else $error("status read misses receive flag");
  flag_hold_a: assert property
    (rx_flag_o && !reg_rd_i && !reg_wr_i |=> rx_flag_o)
    else $error("receive flag lost");
  ifs_start_a: assert property (tx_done_i && !ifs_busy_o |=> ifs_busy_o)
    else $error("spacing not started");
  ack_pulse_a: assert property (ack_tx_o |-> ifs_busy_o ##1 !ack_tx_o)
    else $error("ack pulse outside timer or too long");
endmodule // rff_rx_filter_chk

bind rff_rx_filter rff_rx_filter_chk u_chk (
  .clk_i, .srst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .reg_rvalid_o, .tx_done_i, .ack_tx_o, .ifs_busy_o, .rx_flag_o
);

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb import rff_pkg::*; ;
  localparam int SYM = 4;
  logic       clk_i       = 1'b0;
  logic       srst_i      = 1'b1;
  logic       rx_valid_i;
  logic       rx_ready_o;
  rff_word_t  rx_word_i;
  logic [9:0] reg_addr_i  = '0;
  logic       reg_wr_i    = 1'b0;
  logic       reg_rd_i    = 1'b0;
  logic [7:0] reg_wdata_i = '0;
  logic [7:0] reg_rdata_o, ack_seq_o, got;
  logic       reg_rvalid_o, ack_tx_o, ifs_busy_o, rx_flag_o;
  logic       tx_done_i   = 1'b0;
  logic [7:0] tx_len_i    = '0;
  logic       tx_ackreq_i = 1'b0;
  logic       ack_rcvd_i  = 1'b0;
  int         error_cnt   = 0;
  int         comparisons = 0;
  bit         hung, seen;
  // design and byte source
  rff_rx_filter #(.SYM_CYC(SYM)) dut (.clk_i, .srst_i, .rx_valid_i,
    .rx_ready_o, .rx_word_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
    .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .tx_done_i, .tx_len_i,
    .tx_ackreq_i, .ack_rcvd_i, .ack_tx_o, .ack_seq_o, .ifs_busy_o,
    .rx_flag_o);
  rff_phy_src src (.clk_i, .rdy_i(rx_ready_o), .valid_o(rx_valid_i),
    .word_o(rx_word_i));
  initial forever #12.5 clk_i = ~clk_i;
  // shared checking and bus tasks
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic acc(input logic [9:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1 got = reg_rdata_o;
  endtask
  task automatic rdc(input logic [9:0] a, input logic [7:0] e);
    acc(a, 1'b0, 8'h00);
    chk(got, e);
  endtask
  // sel 0 flag, 1 ack pulse, 2 timer idle; a needed event that is late ends
  task automatic wait_on(input int sel, input int lim, input bit must);
    seen = 0;
    repeat (lim) begin
      @(posedge clk_i);
      #1;
      if (sel == 0 ? rx_flag_o : sel == 1 ? ack_tx_o : !ifs_busy_o) begin
        seen = 1;
        break;
      end
    end
    if (!seen && must) begin
      error_cnt++;
      end_sim();
    end
  endtask
  // one frame, pan then address FFFF; host blocks, reads all, re-enables
  task automatic frame(input logic [7:0] fc0, input logic [7:0] fc1,
                       input logic [15:0] pan, input bit exp);
    src.q = {8'h09, fc0, fc1, 8'h5A, pan[7:0], pan[15:8], 8'hFF, 8'hFF,
             8'hC1, 8'hC2};
    src.send(1, hung);
    chk(hung, 0);
    wait_on(0, 40, 0);
    chk(seen, exp);
    if (seen) begin
      rdc(RFF_INTERRUPT_STATUS_REG, 8'h08);
      chk(rx_flag_o, 0);
      acc(RFF_BB_REG, 1'b1, 8'h04);
      rdc(RFF_RXBUF_BASE, 8'h09);
      for (int i = 1; i < 10; i++) begin
        rdc(RFF_RXBUF_BASE + 10'(i), src.q[i]);
      end
      rdc(RFF_RXBUF_BASE + 10'h00A, 8'h11);
      rdc(RFF_RXBUF_BASE + 10'h00B, 8'h22);
      acc(RFF_BB_REG, 1'b1, 8'h00);
    end
  endtask
  task automatic s_regs();
    rdc(RFF_LIFS_REG, 8'hA0);
    rdc(RFF_SETTLE_REG, 8'h0C);
    rdc(RFF_TURN_REG, 8'hC0);
    rdc(10'h3FF, 8'h00);
    acc(RFF_TURN_REG, 1'b1, 8'hFF);
    rdc(RFF_TURN_REG, 8'hF0);
    acc(RFF_TURN_REG, 1'b1, 8'hC0);
  endtask
  task automatic s_accept();
    frame(8'h21, 8'h08, 16'hFFFF, 1);
    wait_on(1, 100, 1);
    chk(ack_seq_o, 8'h5A);
    wait_on(2, 200, 1);
  endtask
  task automatic s_filter();
    frame(8'h01, 8'h08, 16'h1234, 0);
    acc(RFF_MODE_REG, 1'b1, 8'h01);
    frame(8'h01, 8'h08, 16'h1234, 1);
    src.crc_ok = 1'b0;
    acc(RFF_MODE_REG, 1'b1, 8'h02);
    frame(8'h01, 8'h08, 16'h1234, 1);
    acc(RFF_MODE_REG, 1'b1, 8'h00);
    frame(8'h01, 8'h08, 16'hFFFF, 0);
    src.crc_ok = 1'b1;
    acc(RFF_FLUSH_REG, 1'b1, 8'h08);
    frame(8'h01, 8'h08, 16'hFFFF, 0);
    acc(RFF_FLUSH_REG, 1'b1, 8'h04);
    frame(8'h01, 8'h08, 16'hFFFF, 1);
    acc(RFF_FLUSH_REG, 1'b1, 8'h00);
    acc(RFF_BB_REG, 1'b1, 8'h04);
    frame(8'h01, 8'h08, 16'hFFFF, 0);
    acc(RFF_BB_REG, 1'b1, 8'h00);
    // source-only beacons and data frames carry the source pan
    frame(8'h00, 8'h80, 16'h1234, 0);
    frame(8'h00, 8'h80, 16'h0000, 1);
    frame(8'h01, 8'h80, 16'h0000, 0);
    acc(RFF_MODE_REG, 1'b1, 8'h08);
    frame(8'h01, 8'h80, 16'h0000, 1);
  endtask
  // a stored frame blocks the next one until the buffer is flushed
  task automatic s_hold();
    src.send(1, hung);
    wait_on(0, 40, 1);
    rdc(RFF_INTERRUPT_STATUS_REG, 8'h08);
    src.q[3] = 8'h77;
    src.send(1, hung);
    wait_on(0, 40, 0);
    chk(seen, 0);
    chk(rx_ready_o, 1);
    rdc(RFF_RXBUF_BASE + 10'h003, 8'h5A);
    acc(RFF_FLUSH_REG, 1'b1, 8'h01);
    src.send(1, hung);
    wait_on(0, 40, 1);
    rdc(RFF_RXBUF_BASE + 10'h003, 8'h77);
    chk(hung, 0);
  endtask
  // length of the busy period after a transmitted frame
  task automatic busy(input logic [7:0] len, input logic ack, input int e);
    int n;
    @(posedge clk_i);
    tx_done_i <= 1'b1;
    tx_len_i <= len;
    tx_ackreq_i <= ack;
    @(posedge clk_i);
    tx_done_i <= 1'b0;
    if (ack) begin
      repeat (200) @(posedge clk_i);
      #1 chk(ifs_busy_o, 1);
      @(posedge clk_i);
      ack_rcvd_i <= 1'b1;
      @(posedge clk_i);
      ack_rcvd_i <= 1'b0;
    end
    n = 0;
    #1 while (ifs_busy_o && n < 400) begin
      @(posedge clk_i);
      #1 n++;
    end
    chk(n >= e - 2 && n <= e + 2, 1);
  endtask
  task automatic s_ifs();
    acc(RFF_SETTLE_REG, 1'b1, 8'h12);
    busy(8'd18, 1'b0, 3 * SYM);
    busy(8'd19, 1'b0, 41 * SYM);
    busy(8'd10, 1'b1, 3 * SYM);
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    s_regs();
    s_accept();
    s_filter();
    s_hold();
    s_ifs();
    end_sim();
  end
endmodule // tb
